// [sriov_vf_function_mapping.sv]
// Overview of operation
// - Each physical function holds a 4-bit capability version and reports it.
// - At most six virtual functions in total, split between both physical functions.
// - Physical function zero is function 0; physical function one is function 1.
// - Virtual functions occupy only function numbers 64 to 69.
// - Virtual functions numbered consecutively, zero's first, then one's.
// - First-VF offset equals first VF function number minus own function number.
// - Function zero's first-VF offset is 64 whenever it has any VF.
// - Function one's first-VF offset is 63 plus function zero's VF count whenever it has any VF.
// - Each function's 16-bit VF device ID is reported by all its VFs.
// - Supported page sizes are a 32-bit map, bit n means 2^(n+12) bytes.
// - Each function holds and reports its dependency link unchanged.
// - Capability exists for function zero while sriov_en is set, and for one when pf1_en is also set.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sriov_vf_function_mapping
	import sriov_map_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output var  logic [31:0] rdata_o,
	input  wire logic [7:0]  lookup_fn_i,
	output var  fn_map_t     lookup_o,
	output var  pf_cap_t     [1:0] pf_cap_o
);

	// ==========================================================
	// Configuration state
	// ==========================================================
	logic        sriov_en;
	logic        pf1_en;
	logic        rejected;
	logic [7:0]  query;
	logic [3:0]  version    [2];
	logic [2:0]  count      [2];
	logic [2:0]  stage      [2];
	logic [15:0] dep_link   [2];
	logic [15:0] dev_id     [2];
	logic [31:0] pages      [2];
	logic        next_sriov_en;
	logic        next_pf1_en;
	logic        next_rejected;
	logic [7:0]  next_query;
	logic [3:0]  next_version  [2];
	logic [2:0]  next_count    [2];
	logic [2:0]  next_stage    [2];
	logic [15:0] next_dep_link [2];
	logic [15:0] next_dev_id   [2];
	logic [31:0] next_pages    [2];
	logic [3:0]  stage_sum;
	logic [15:0] first_ofs     [2];
	logic [31:0] next_rdata;
	pf_cap_t     [1:0] next_cap;
	fn_map_t     query_map;

	function automatic logic [7:0] pf_addr(input int unsigned p, input logic [7:0] ofs);
		return 8'(REG_PF_BASE + 8'(p) * PF_STRIDE + ofs);
	endfunction

	assign stage_sum = {1'b0, stage[0]} + {1'b0, stage[1]};

	// The counts take effect only together and only if they fit the range.
	always_comb begin
		next_sriov_en = sriov_en;
		next_pf1_en   = pf1_en;
		next_rejected = rejected;
		next_query    = query;
		next_version  = version;
		next_count    = count;
		next_stage    = stage;
		next_dep_link = dep_link;
		next_dev_id   = dev_id;
		next_pages    = pages;
		if (wr_i) begin
			if (addr_i == REG_STATUS && wdata_i[STAT_REJ_BIT]) begin
				next_rejected = 1'b0;
			end
			if (addr_i == REG_QUERY) begin
				next_query = wdata_i[7:0];
			end
			if (addr_i == REG_CTRL) begin
				next_sriov_en = wdata_i[CTRL_EN_BIT];
				next_pf1_en   = wdata_i[CTRL_PF1_BIT];
				if (wdata_i[CTRL_APPLY_BIT]) begin
					if (stage_sum <= {1'b0, MAX_VFS}) begin
						next_count = stage;
					end else begin
						next_rejected = 1'b1;
					end
				end
			end
			for (int p = 0; p < 2; p++) begin
				if (addr_i == pf_addr(p, OFS_CFG)) begin
					next_version[p] = wdata_i[CFG_VER_LSB +: 4];
					next_stage[p]   = wdata_i[CFG_CNT_LSB +: 3];
				end
				if (addr_i == pf_addr(p, OFS_DEP_LINK)) begin
					next_dep_link[p] = wdata_i[15:0];
				end
				if (addr_i == pf_addr(p, OFS_VF_DEV_ID)) begin
					next_dev_id[p] = wdata_i[15:0];
				end
				if (addr_i == pf_addr(p, OFS_PAGES)) begin
					next_pages[p] = wdata_i;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sriov_en    <= RST_SRIOV_EN;
			pf1_en      <= RST_PF1_EN;
			rejected    <= 1'b0;
			query       <= FN_PF0;
			dep_link[0] <= RST_DEP_PF0;
			dep_link[1] <= RST_DEP_PF1;
			for (int p = 0; p < 2; p++) begin
				version[p] <= RST_VERSION;
				count[p]   <= RST_VF_COUNT;
				stage[p]   <= RST_VF_COUNT;
				dev_id[p]  <= RST_DEV_ID;
				pages[p]   <= RST_PAGES;
			end
		end else begin
			sriov_en <= next_sriov_en;
			pf1_en   <= next_pf1_en;
			rejected <= next_rejected;
			query    <= next_query;
			version  <= next_version;
			count    <= next_count;
			stage    <= next_stage;
			dep_link <= next_dep_link;
			dev_id   <= next_dev_id;
			pages    <= next_pages;
		end
	end

	// ==========================================================
	// First-VF offsets and capability outputs
	// ==========================================================
	// Function zero sits at 0, so its offset is the base itself; function one sits at 1.
	always_comb begin
		first_ofs[0] = (count[0] != 3'h0) ? PF0_FIRST_OFFSET : 16'h0000;
		first_ofs[1] = (count[1] != 3'h0) ? PF1_OFFSET_BASE + {13'h0000, count[0]} : 16'h0000;
		for (int p = 0; p < 2; p++) begin
			next_cap[p].present      = sriov_en && (p == 0 || pf1_en);
			next_cap[p].version      = version[p];
			next_cap[p].total_vfs    = count[p];
			next_cap[p].first_offset = first_ofs[p];
			next_cap[p].dep_link     = dep_link[p];
			next_cap[p].vf_dev_id    = dev_id[p];
			next_cap[p].page_sizes   = pages[p];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pf_cap_o <= '0;
		end else begin
			pf_cap_o <= next_cap;
		end
	end

	// ==========================================================
	// Register read port
	// ==========================================================
	assign query_map = decode_fn(query, sriov_en, pf1_en, count[0], count[1]);

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			if (addr_i == REG_CTRL) begin
				next_rdata[CTRL_EN_BIT]  = sriov_en;
				next_rdata[CTRL_PF1_BIT] = pf1_en;
			end
			if (addr_i == REG_STATUS) begin
				next_rdata[STAT_REJ_BIT]        = rejected;
				next_rdata[STAT_CNT0_LSB +: 3] = count[0];
				next_rdata[STAT_CNT1_LSB +: 3] = count[1];
			end
			if (addr_i == REG_QUERY) begin
				next_rdata[QRY_HIT_BIT]       = query_map.hit;
				next_rdata[QRY_VF_BIT]        = query_map.is_vf;
				next_rdata[QRY_PF_BIT]        = query_map.pf;
				next_rdata[QRY_IDX_LSB +: 3]  = query_map.vf_index;
				if (query_map.is_vf) begin
					next_rdata[QRY_DEV_LSB +: 16] = dev_id[query_map.pf];
				end
			end
			if (addr_i == REG_FIRST_OFS) begin
				next_rdata = {first_ofs[1], first_ofs[0]};
			end
			for (int p = 0; p < 2; p++) begin
				if (addr_i == pf_addr(p, OFS_CFG)) begin
					next_rdata[CFG_VER_LSB +: 4] = version[p];
					next_rdata[CFG_CNT_LSB +: 3] = stage[p];
				end
				if (addr_i == pf_addr(p, OFS_DEP_LINK)) begin
					next_rdata[15:0] = dep_link[p];
				end
				if (addr_i == pf_addr(p, OFS_VF_DEV_ID)) begin
					next_rdata[15:0] = dev_id[p];
				end
				if (addr_i == pf_addr(p, OFS_PAGES)) begin
					next_rdata = pages[p];
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// ==========================================================
	// Function-number lookup for the core
	// ==========================================================
	fn_mapper u_mapper (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.fn_i     (lookup_fn_i),
		.en_i     (sriov_en),
		.pf1_en_i (pf1_en),
		.count0_i (count[0]),
		.count1_i (count[1]),
		.map_o    (lookup_o)
	);

	// ==========================================================
	// Assertions
	// ==========================================================
	// Reset is released on a clock edge, so checks also stay quiet for the one edge after it.
	logic was_reset;

	always_ff @(posedge clock_i) begin
		was_reset <= rst_i;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i || was_reset);

	property p_total_limit;
		({1'b0, count[0]} + {1'b0, count[1]}) <= 4'h6;
	endproperty
	a_total_limit: assert property (p_total_limit) else $error("VF total exceeds six");

	property p_reject_bad;
		wr_i && addr_i == REG_CTRL && wdata_i[CTRL_APPLY_BIT] && stage_sum > 4'h6
			|=> $stable(count[0]) && $stable(count[1]) && rejected;
	endproperty
	a_reject_bad: assert property (p_reject_bad) else $error("Invalid VF counts applied");

	property p_pf0_offset;
		count[0] != 3'h0 |=> pf_cap_o[0].first_offset == 16'h0040;
	endproperty
	a_pf0_offset: assert property (p_pf0_offset) else $error("Function zero offset not 64");

	property p_pf1_offset;
		count[1] != 3'h0 |=> pf_cap_o[1].first_offset == 16'h003f + {13'h0000, $past(count[0])};
	endproperty
	a_pf1_offset: assert property (p_pf1_offset) else $error("Function one offset wrong");

	property p_vf_range;
		lookup_o.is_vf |-> $past(lookup_fn_i) >= 8'h40 && $past(lookup_fn_i) <= 8'h45;
	endproperty
	a_vf_range: assert property (p_vf_range) else $error("VF outside 64 to 69");

	property p_pf_numbers;
		lookup_fn_i == FN_PF0 |=> lookup_o.hit && !lookup_o.is_vf && !lookup_o.pf;
	endproperty
	a_pf_numbers: assert property (p_pf_numbers) else $error("Function 0 not function zero");

	property p_pf1_number;
		lookup_fn_i == FN_PF1 |=> lookup_o.pf && !lookup_o.is_vf && lookup_o.hit == $past(pf1_en);
	endproperty
	a_pf1_number: assert property (p_pf1_number) else $error("Function 1 not function one");

	property p_consecutive;
		sriov_en && pf1_en && count[1] != 3'h0 && $stable(count[0]) && lookup_fn_i == 8'h40 + {5'h00, count[0]}
			|=> lookup_o.hit && lookup_o.is_vf && lookup_o.pf && lookup_o.vf_index == 3'h0;
	endproperty
	a_consecutive: assert property (p_consecutive) else $error("Function one VFs not after zero's");

	property p_present;
		!sriov_en || !pf1_en |=> !pf_cap_o[1].present;
	endproperty
	a_present: assert property (p_present) else $error("Capability shown while disabled");

	property p_report_fields;
		wr_i && addr_i == pf_addr(1, OFS_VF_DEV_ID) ##1 !(wr_i && addr_i == pf_addr(1, OFS_VF_DEV_ID))
			|=> pf_cap_o[1].vf_dev_id == $past(wdata_i[15:0], 2);
	endproperty
	a_report_fields: assert property (p_report_fields) else $error("VF device ID not reported");

	property p_version;
		wr_i && addr_i == pf_addr(0, OFS_CFG) ##1 !(wr_i && addr_i == pf_addr(0, OFS_CFG))
			|=> pf_cap_o[0].version == $past(wdata_i[3:0], 2);
	endproperty
	a_version: assert property (p_version) else $error("Version not reported");

	c_apply_ok: cover property (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_APPLY_BIT] && stage_sum == 4'h6);
	c_reject:   cover property ($rose(rejected));
	c_vf_pf1:   cover property (lookup_o.is_vf && lookup_o.pf);

endmodule
`default_nettype wire

// [sriov_map_pkg.sv]
package sriov_map_pkg;

	// ==========================================================
	// Register map and fields
	// ==========================================================
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_QUERY     = 8'h08;
	localparam logic [7:0] REG_PF_BASE   = 8'h10;
	localparam logic [7:0] PF_STRIDE     = 8'h10;
	localparam logic [7:0] OFS_CFG       = 8'h00;
	localparam logic [7:0] OFS_DEP_LINK  = 8'h04;
	localparam logic [7:0] OFS_VF_DEV_ID = 8'h08;
	localparam logic [7:0] OFS_PAGES     = 8'h0c;
	localparam logic [7:0] REG_FIRST_OFS = 8'h30;

	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_PF1_BIT   = 1;
	localparam int unsigned CTRL_APPLY_BIT = 2;
	localparam int unsigned STAT_REJ_BIT   = 0;
	localparam int unsigned CFG_VER_LSB    = 0;
	localparam int unsigned CFG_CNT_LSB    = 8;
	localparam int unsigned STAT_CNT0_LSB  = 4;
	localparam int unsigned STAT_CNT1_LSB  = 8;
	localparam int unsigned QRY_HIT_BIT    = 0;
	localparam int unsigned QRY_VF_BIT     = 1;
	localparam int unsigned QRY_PF_BIT     = 2;
	localparam int unsigned QRY_IDX_LSB    = 4;
	localparam int unsigned QRY_DEV_LSB    = 16;

	// ==========================================================
	// Function numbering
	// ==========================================================
	localparam logic [2:0]  MAX_VFS          = 3'h6;
	localparam logic [7:0]  FN_PF0           = 8'h00;
	localparam logic [7:0]  FN_PF1           = 8'h01;
	localparam logic [7:0]  FN_VF_BASE       = 8'h40;
	localparam logic [7:0]  FN_VF_LAST       = 8'h45;
	localparam logic [15:0] PF0_FIRST_OFFSET = 16'h0040;
	localparam logic [15:0] PF1_OFFSET_BASE  = 16'h003f;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic        RST_SRIOV_EN = 1'h1;
	localparam logic        RST_PF1_EN   = 1'h1;
	localparam logic [2:0]  RST_VF_COUNT = 3'h1;
	localparam logic [3:0]  RST_VERSION  = 4'h0;
	localparam logic [15:0] RST_DEP_PF0  = 16'h0000;
	localparam logic [15:0] RST_DEP_PF1  = 16'h0001;
	localparam logic [15:0] RST_DEV_ID   = 16'h0000;
	localparam logic [31:0] RST_PAGES    = 32'h0000_0001;

	typedef struct packed {
		logic        present;
		logic [3:0]  version;
		logic [2:0]  total_vfs;
		logic [15:0] first_offset;
		logic [15:0] dep_link;
		logic [15:0] vf_dev_id;
		logic [31:0] page_sizes;
	} pf_cap_t;

	typedef struct packed {
		logic       hit;
		logic       is_vf;
		logic       pf;
		logic [2:0] vf_index;
	} fn_map_t;

	// Resolves a function number into its owning function.
	function automatic fn_map_t decode_fn(input logic [7:0] fn, input logic en, input logic pf1_en,
	                                      input logic [2:0] c0, input logic [2:0] c1);
		fn_map_t    m;
		logic [7:0] rel;
		logic [7:0] lim0;
		logic [7:0] lim1;
		m    = '0;
		rel  = fn - FN_VF_BASE;
		lim0 = {5'h00, c0};
		lim1 = lim0 + {5'h00, c1};
		if (fn == FN_PF0) begin
			m.hit = 1'b1;
		end else if (fn == FN_PF1) begin
			m.hit = pf1_en;
			m.pf  = 1'b1;
		end else if (en && fn >= FN_VF_BASE && fn <= FN_VF_LAST) begin
			if (rel < lim0) begin
				m.hit      = 1'b1;
				m.is_vf    = 1'b1;
				m.vf_index = rel[2:0];
			end else if (pf1_en && rel < lim1) begin
				m.hit      = 1'b1;
				m.is_vf    = 1'b1;
				m.pf       = 1'b1;
				m.vf_index = rel[2:0] - c0;
			end
		end
		return m;
	endfunction

endpackage

// [fn_mapper.sv]
`timescale 1ns/1ps
`default_nettype none
module fn_mapper
	import sriov_map_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] fn_i,
	input  wire logic       en_i,
	input  wire logic       pf1_en_i,
	input  wire logic [2:0] count0_i,
	input  wire logic [2:0] count1_i,
	output var  fn_map_t    map_o
);

	fn_map_t next_map;

	always_comb begin
		next_map = decode_fn(fn_i, en_i, pf1_en_i, count0_i, count1_i);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			map_o <= '0;
		end else begin
			map_o <= next_map;
		end
	end

endmodule
`default_nettype wire

// [cfg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Configuration software bus master
// ==========================================
module cfg_host_model (
	input  wire logic        clock_i,
	input  wire logic [31:0] rdata_i,
	output var  logic [7:0]  addr_o,
	output var  logic [31:0] wdata_o,
	output var  logic        wr_o,
	output var  logic        rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0000_0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// Write data is inverted once released so that stale data never looks valid.
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clock_i);
		wr_o    <= 1'b0;
		wdata_o <= ~d;
	endtask

	task automatic get(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// [sriov_vf_function_mapping_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sriov_vf_function_mapping_bench import sriov_map_pkg::*;;
	logic        clock = 1'b0;
	logic        rst   = 1'b1;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [7:0]  lookup_fn = 8'h00;
	fn_map_t     lookup;
	pf_cap_t     [1:0] pf_cap;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	always #5 clock = ~clock;

	sriov_vf_function_mapping dut_u (.clock_i(clock), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lookup_fn_i(lookup_fn), .lookup_o(lookup), .pf_cap_o(pf_cap));
	cfg_host_model host_u (.clock_i(clock), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));

	// ==========================================
	// Checking helpers
	// ==========================================
	task automatic end_sim;
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		host_u.get(a, d);
		chk(d, e);
	endtask

	function automatic logic [7:0] pfa(input int p, input logic [7:0] o);
		return 8'(REG_PF_BASE + PF_STRIDE * p + o);
	endfunction

	// Walks functions 0, 1 and 0x40 to 0x47 through the lookup port.
	task automatic t_map(input logic en, input logic p1, input int c0, input int c1);
		fn_map_t e;
		int      i;
		for (int j = 0; j < 10; j++) begin
			i = j - 2;
			e = '0;
			if (j < 2) begin
				e.hit = (j == 0) || p1;
				e.pf  = (j == 1);
			end else if (en && i < c0) begin
				e.hit      = 1'b1;
				e.is_vf    = 1'b1;
				e.vf_index = 3'(i);
			end else if (en && p1 && i < c0 + c1) begin
				e.hit      = 1'b1;
				e.is_vf    = 1'b1;
				e.pf       = 1'b1;
				e.vf_index = 3'(i - c0);
			end
			@(posedge clock);
			lookup_fn <= (j < 2) ? 8'(j) : 8'(j + 62);
			@(posedge clock);
			#1;
			chk(32'(lookup), 32'(e));
		end
	endtask

	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_reset;
		rd_chk(REG_CTRL, 32'h0000_0003);
		rd_chk(REG_STATUS, 32'h0000_0110);
		rd_chk(pfa(0, OFS_CFG), 32'h0000_0100);
		rd_chk(pfa(1, OFS_DEP_LINK), 32'h0000_0001);
		rd_chk(pfa(1, OFS_VF_DEV_ID), 32'h0000_0000);
		rd_chk(pfa(0, OFS_PAGES), 32'h0000_0001);
		rd_chk(REG_FIRST_OFS, 32'h0040_0040);
		// Read data stand for one cycle only and then fall back to zero.
		@(posedge clock);
		#1;
		chk(rdata, 32'h0000_0000);
		rd_chk(8'hfc, 32'h0000_0000);
		chk(32'(pf_cap[1].present), 32'h0000_0001);
	endtask

	task automatic t_fields;
		for (int p = 0; p < 2; p++) begin
			host_u.put(pfa(p, OFS_CFG), 32'h100 + p + 10);
			host_u.put(pfa(p, OFS_DEP_LINK), 32'h1234 + p);
			host_u.put(pfa(p, OFS_VF_DEV_ID), 32'hbee0 + p);
			host_u.put(pfa(p, OFS_PAGES), 32'h8000_0013 << p);
		end
		host_u.put(8'hfc, 32'hffff_ffff);
		rd_chk(8'hfc, 32'h0000_0000);
		for (int p = 0; p < 2; p++) begin
			rd_chk(pfa(p, OFS_CFG), 32'h100 + p + 10);
			rd_chk(pfa(p, OFS_DEP_LINK), 32'h1234 + p);
			rd_chk(pfa(p, OFS_VF_DEV_ID), 32'hbee0 + p);
			rd_chk(pfa(p, OFS_PAGES), 32'h8000_0013 << p);
			chk(32'(pf_cap[p].version), 32'(p + 10));
			chk(32'(pf_cap[p].dep_link), 32'h1234 + p);
			chk(32'(pf_cap[p].vf_dev_id), 32'hbee0 + p);
			chk(pf_cap[p].page_sizes, 32'h8000_0013 << p);
		end
	endtask

	task automatic t_apply(input int c0, input int c1);
		int o0;
		int o1;
		o0 = (c0 > 0) ? 64 : 0;
		o1 = (c1 > 0) ? 63 + c0 : 0;
		host_u.put(pfa(0, OFS_CFG), 32'((c0 << 8) + 10));
		host_u.put(pfa(1, OFS_CFG), 32'((c1 << 8) + 11));
		host_u.put(REG_CTRL, 32'h7);
		rd_chk(REG_STATUS, 32'((c1 << 8) | (c0 << 4)));
		rd_chk(REG_FIRST_OFS, 32'((o1 << 16) | o0));
		chk(32'(pf_cap[0].first_offset), 32'(o0));
		chk(32'(pf_cap[1].first_offset), 32'(o1));
		chk(32'(pf_cap[0].total_vfs), 32'(c0));
		chk(32'(pf_cap[1].total_vfs), 32'(c1));
		t_map(1'b1, 1'b1, c0, c1);
		if (c1 > 0) begin
			host_u.put(REG_QUERY, 32'(64 + c0));
			rd_chk(REG_QUERY, 32'hbee1_0007);
		end
	endtask

	task automatic t_reject;
		host_u.put(pfa(0, OFS_CFG), 32'h0000_040a);
		host_u.put(pfa(1, OFS_CFG), 32'h0000_030b);
		host_u.put(REG_CTRL, 32'h7);
		rd_chk(REG_STATUS, 32'h0000_0241);
		rd_chk(REG_FIRST_OFS, 32'h0043_0040);
		host_u.put(REG_STATUS, 32'h1);
		rd_chk(REG_STATUS, 32'h0000_0240);
	endtask

	task automatic t_pf1_off;
		host_u.put(REG_CTRL, 32'h1);
		t_map(1'b1, 1'b0, 4, 2);
		chk(32'(pf_cap[1].present), 32'h0000_0000);
		chk(32'(pf_cap[0].present), 32'h0000_0001);
		host_u.put(REG_CTRL, 32'h0);
		t_map(1'b0, 1'b0, 4, 2);
		chk(32'(pf_cap[0].present), 32'h0000_0000);
		host_u.put(REG_CTRL, 32'h3);
		t_map(1'b1, 1'b1, 4, 2);
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_apply(2, 3);
		t_apply(0, 6);
		t_apply(6, 0);
		t_apply(4, 2);
		t_reject();
		t_pf1_off();
		end_sim();
	end
endmodule
`default_nettype wire
